// [rtl/nvsc_host.sv]
// host controller issuing accesses and save/recall commands to nvsram
`timescale 1ns/1ps
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int SAVE_CYC = NVSC_SAVE_US * NVSC_CLK_MHZ,
  parameter int LOAD_CYC = NVSC_LOAD_US * NVSC_CLK_MHZ
)(
  input wire logic core_clk, // 25 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic reqValid, // request strobe
  input nvsc_req_t req, // request contents
  output logic reqReady, // ready for a request
  output logic rdValid, // read data pulse
  output logic [7:0] rdData, // read data
  output logic cmdDone, // command finished pulse
  output logic cmdSkipped, // command dropped at low supply, or hardware save found no busy
  output nvsc_pins_t pins, // memory pins
  input wire logic [7:0] dqIn, // data pins in
  output logic saveReqOut, // save pin driven low
  output logic saveReqOe, // save pin output enable
  input wire logic saveIn, // save pin level
  input wire logic lowSupply // low supply flag
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACC = 3'b001,
    ST_GAP = 3'b011,
    ST_HWREQ = 3'b010,
    ST_BUSYW = 3'b110,
    ST_WAIT = 3'b111
  } nvsc_state_t;

  nvsc_state_t st_q, st_d;
  nvsc_req_t cur_q, cur_d;
  nvsc_pins_t pin_q, pin_d;
  logic [2:0] step_q, step_d;
  logic [19:0] cnt_q, cnt_d;
  logic rdv_q, rdv_d, done_q, done_d, skip_q, skip_d;
  logic [7:0] rdd_q, rdd_d;
  logic hsb_q, hsb_d, sawBusy_q, sawBusy_d;
  logic rdy_q, rdy_d;
  logic busyLow;
  logic seqCmd;

  nvsc_busy_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn(saveIn),
    .busyLow(busyLow)
  );

  assign seqCmd = (cur_q.cmd != NVSC_CMD_READ) &&
                  (cur_q.cmd != NVSC_CMD_WRITE) &&
                  (cur_q.cmd != NVSC_CMD_HWSAVE);

  // =====================================================
  // sequencer next state
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    pin_d = pin_q;
    step_d = step_q;
    cnt_d = cnt_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    done_d = 1'b0;
    skip_d = 1'b0;
    hsb_d = hsb_q;
    sawBusy_d = sawBusy_q;
    case (st_q)
      ST_IDLE: begin
        // hold off while device is busy with any save
        if (reqValid && !busyLow) begin
          cur_d = req;
          step_d = 3'h0;
          // low supply: drop writes and saves
          if (lowSupply && (req.cmd == NVSC_CMD_WRITE ||
              req.cmd == NVSC_CMD_SWSAVE || req.cmd == NVSC_CMD_HWSAVE)) begin
            skip_d = 1'b1;
          end else if (req.cmd == NVSC_CMD_HWSAVE) begin
            hsb_d = 1'b1;
            sawBusy_d = 1'b0;
            cnt_d = NVSC_CNT_ZERO;
            st_d = ST_HWREQ;
          end else begin
            st_d = ST_ACC;
            cnt_d = NVSC_CNT_ZERO;
            pin_d.chipSelN = 1'b0;
            // commands use reads, write strobe high
            pin_d.writeN = (req.cmd != NVSC_CMD_WRITE);
            pin_d.outEnN = (req.cmd == NVSC_CMD_WRITE);
            pin_d.dqOe = (req.cmd == NVSC_CMD_WRITE);
            pin_d.dqOut = req.wdata;
            if (req.cmd == NVSC_CMD_READ || req.cmd == NVSC_CMD_WRITE)
              pin_d.addr = req.addr;
            else
              pin_d.addr = {1'b0, nvsc_step_addr(3'h0, req.cmd)};
          end
        end
      end
      ST_ACC: begin
        cnt_d = cnt_q + NVSC_CNT_ONE;
        if (cnt_q == 20'(NVSC_ACC_CYC - 1)) begin
          rdd_d = dqIn;
          // release strobes so each access has its own falling edge
          pin_d.chipSelN = 1'b1;
          pin_d.writeN = 1'b1;
          pin_d.outEnN = 1'b1;
          pin_d.dqOe = 1'b0;
          cnt_d = NVSC_CNT_ZERO;
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!seqCmd) begin
          rdv_d = (cur_q.cmd == NVSC_CMD_READ);
          done_d = 1'b1;
          st_d = ST_IDLE;
        end else if (step_q == 3'h5) begin
          // sixth read issued, wait out the operation
          cnt_d = NVSC_CNT_ZERO;
          st_d = ST_WAIT;
        end else begin
          // next read back to back, nothing else interleaved
          step_d = step_q + 3'h1;
          pin_d.chipSelN = 1'b0;
          pin_d.outEnN = 1'b0;
          pin_d.addr = {1'b0, nvsc_step_addr(step_q + 3'h1, cur_q.cmd)};
          st_d = ST_ACC;
        end
      end
      ST_HWREQ: begin
        // hold request for a fixed window of NVSC_HOLD_CYC + NVSC_BUSY_WAIT_CYC + 1 cycles
        cnt_d = cnt_q + NVSC_CNT_ONE;
        // own pull-down reads as busy here, so it is not counted
        if (cnt_q == 20'(NVSC_HOLD_CYC + NVSC_BUSY_WAIT_CYC)) begin
          hsb_d = 1'b0;
          st_d = ST_BUSYW;
          cnt_d = NVSC_CNT_ZERO;
        end
      end
      ST_BUSYW: begin
        // wait for pin to go high again, save done
        cnt_d = cnt_q + NVSC_CNT_ONE;
        // own release needs the synchroniser delay to show
        if (busyLow && cnt_q >= 20'(NVSC_SYNC_CYC))
          sawBusy_d = 1'b1;
        if (!busyLow && cnt_q >= 20'(NVSC_BUSY_WAIT_CYC)) begin
          done_d = sawBusy_q;
          skip_d = !sawBusy_q;
          st_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // memory locked for save or recall time
        // a software save also makes a changed autosave setting stick
        cnt_d = cnt_q + NVSC_CNT_ONE;
        if ((cur_q.cmd == NVSC_CMD_SWSAVE && cnt_q >= 20'(SAVE_CYC - 1)) ||
            (cur_q.cmd == NVSC_CMD_RECALL && cnt_q >= 20'(LOAD_CYC - 1)) ||
            (cur_q.cmd == NVSC_CMD_ASOFF || cur_q.cmd == NVSC_CMD_ASON)) begin
          if (!busyLow) begin
            done_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // ready is registered so the port comes from a flop
    rdy_d = (st_d == ST_IDLE);
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      pin_q <= '{chipSelN: 1'b1, writeN: 1'b1, outEnN: 1'b1,
                 addr: 15'h0000, dqOut: 8'h00, dqOe: 1'b0};
      step_q <= 3'h0;
      cnt_q <= NVSC_CNT_ZERO;
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      hsb_q <= 1'b0;
      sawBusy_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      pin_q <= pin_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
      done_q <= done_d;
      skip_q <= skip_d;
      hsb_q <= hsb_d;
      sawBusy_q <= sawBusy_d;
      rdy_q <= rdy_d;
    end
  end

  // outputs from flops, saveReqOut tied low
  assign pins = pin_q;
  assign rdValid = rdv_q;
  assign rdData = rdd_q;
  assign cmdDone = done_q;
  assign cmdSkipped = skip_q;
  assign saveReqOut = 1'b0;
  assign saveReqOe = hsb_q;
  assign reqReady = rdy_q;

  // =====================================================
  // checks
  chk_seq_writen: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_ACC && seqCmd) |-> pin_q.writeN)
    else $error("write strobe low in command");
  chk_seq_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_ACC && seqCmd) |->
      pin_q.addr[13:0] == nvsc_step_addr(step_q, cur_q.cmd))
    else $error("wrong command address");
  chk_seq_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_GAP && seqCmd && step_q != 3'h5) |=>
      (st_q == ST_ACC && !pin_q.chipSelN))
    else $error("gap in command sequence");
  chk_low_nowr: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_IDLE && reqValid && lowSupply &&
     req.cmd == NVSC_CMD_WRITE) |=> (st_q == ST_IDLE && pin_q.writeN))
    else $error("write issued at low supply");
  chk_wait_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_WAIT) |-> pin_q.chipSelN)
    else $error("access during save or recall");
  chk_cs_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_ACC && cnt_q == 20'(NVSC_ACC_CYC - 1)) |=>
      pin_q.chipSelN)
    else $error("chip select not released");
  chk_hw_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hsb_q) |-> hsb_q [*4])
    else $error("save request too short");
  chk_busy_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (busyLow && st_q != ST_GAP) |=>
      !(st_q == ST_ACC && cnt_q == NVSC_CNT_ZERO))
    else $error("access started while busy");
  cov_swsave: cover property (@(posedge core_clk)
    st_q == ST_WAIT && cur_q.cmd == NVSC_CMD_SWSAVE);
  cov_recall: cover property (@(posedge core_clk)
    st_q == ST_WAIT && cur_q.cmd == NVSC_CMD_RECALL);
  cov_hwsave: cover property (@(posedge core_clk) done_q && sawBusy_q);
  cov_skip: cover property (@(posedge core_clk) skip_q);
endmodule

// [rtl/nvsc_pkg.sv]
// package of constants and carrier types for the nvsram host controller
package nvsc_pkg;
  // =====================================================
  // bus geometry
  localparam int NVSC_AW = 15;
  localparam int NVSC_CW = 14;
  localparam int NVSC_DW = 8;
  // =====================================================
  // command addresses
  localparam logic [13:0] NVSC_SEQ0 = 14'h0E38;
  localparam logic [13:0] NVSC_SEQ1 = 14'h31C7;
  localparam logic [13:0] NVSC_SEQ2 = 14'h03E0;
  localparam logic [13:0] NVSC_SEQ3 = 14'h3C1F;
  localparam logic [13:0] NVSC_SEQ4 = 14'h303F;
  localparam logic [13:0] NVSC_SAVE = 14'h0FC0;
  localparam logic [13:0] NVSC_LOAD = 14'h0C63;
  localparam logic [13:0] NVSC_ASOFF = 14'h03F8;
  localparam logic [13:0] NVSC_ASON = 14'h07F0;
  // =====================================================
  // timing
  localparam int NVSC_CLK_MHZ = 25;
  localparam int NVSC_ACC_NS = 120;
  localparam int NVSC_ACC_CYC = (NVSC_ACC_NS * NVSC_CLK_MHZ + 999) / 1000;
  localparam int NVSC_HOLD_NS = 200;
  localparam int NVSC_HOLD_CYC = (NVSC_HOLD_NS * NVSC_CLK_MHZ + 999) / 1000;
  localparam int NVSC_SAVE_US = 10000;
  localparam int NVSC_LOAD_US = 200;
  localparam int NVSC_BUSY_WAIT_CYC = 8;
  localparam int NVSC_SYNC_CYC = 2;
  localparam int NVSC_CW_CNT = 20;
  localparam logic [19:0] NVSC_CNT_ONE = 20'h00001;
  localparam logic [19:0] NVSC_CNT_ZERO = 20'h00000;
  // =====================================================
  // commands
  typedef enum logic [2:0] {
    NVSC_CMD_READ = 3'h0,
    NVSC_CMD_WRITE = 3'h1,
    NVSC_CMD_SWSAVE = 3'h2,
    NVSC_CMD_RECALL = 3'h3,
    NVSC_CMD_ASOFF = 3'h4,
    NVSC_CMD_ASON = 3'h5,
    NVSC_CMD_HWSAVE = 3'h6
  } nvsc_cmd_t;

  typedef struct packed {
    nvsc_cmd_t cmd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } nvsc_req_t;

  typedef struct packed {
    logic chipSelN;
    logic writeN;
    logic outEnN;
    logic [14:0] addr;
    logic [7:0] dqOut;
    logic dqOe;
  } nvsc_pins_t;

  // command address for one step of a sequence
  function automatic logic [13:0] nvsc_step_addr(input logic [2:0] step,
                                                 input nvsc_cmd_t cmd);
    logic [13:0] a;
    a = NVSC_SEQ0;
    case (step)
      3'h0: a = NVSC_SEQ0;
      3'h1: a = NVSC_SEQ1;
      3'h2: a = NVSC_SEQ2;
      3'h3: a = NVSC_SEQ3;
      3'h4: a = NVSC_SEQ4;
      default: begin
        case (cmd)
          NVSC_CMD_SWSAVE: a = NVSC_SAVE;
          NVSC_CMD_RECALL: a = NVSC_LOAD;
          NVSC_CMD_ASOFF: a = NVSC_ASOFF;
          default: a = NVSC_ASON;
        endcase
      end
    endcase
    return a;
  endfunction
endpackage

// [rtl/nvsc_busy_sync.sv]
// two-flop synchroniser for the save/busy pin
`timescale 1ns/1ps
module nvsc_busy_sync
  import nvsc_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic pinIn, // raw save/busy pin level
  output logic busyLow // synchronised low level
);
  logic s1_q, s1_d, s2_q, s2_d;

  // next values of the synchroniser
  always_comb begin
    s1_d = pinIn;
    s2_d = s1_q;
  end

  // register stage, idle level is high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign busyLow = ~s2_q;
endmodule

// [verif/nvsc_nvram_model.sv]
// behavioural nvsram device facing the host controller
`timescale 1ns/1ps
module nvsc_nvram_model
  import nvsc_pkg::*;
#(
  parameter int SAVE_T = 30,
  parameter int LOAD_T = 12
)(
  input wire logic core_clk, // bench clock
  input nvsc_pins_t pins, // memory pins from host
  input wire logic saveReqOe, // host pulls save pin low
  input wire logic lowSupply, // supply below low_supply_trip
  output logic [7:0] dqIn, // data to host
  output logic saveIn // save pin level
);
  // ==========================================================
  // storage and state
  logic [7:0] mem [int];
  logic [7:0] nv [int];
  logic [13:0] seq [5] = '{NVSC_SEQ0, NVSC_SEQ1, NVSC_SEQ2, NVSC_SEQ3,
                           NVSC_SEQ4};
  int step = 0;
  int busyCnt = 0;
  logic dirty = 1'b0;
  logic autoSaveEn = 1'b1;
  logic autoSaveNv = 1'b1;
  logic busyN = 1'b1;
  logic csLast = 1'b1;
  logic wrSeen = 1'b0;
  logic wrArm = 1'b0;
  logic weLast = 1'b1;
  logic [14:0] a = 15'h0000;
  logic [7:0] wd = 8'h00;
  logic [13:0] c;
  initial dqIn = 8'h00;
  // open-drain pin with a pull-up
  assign saveIn = busyN & ~saveReqOe;
  // erase then program, pin low until nv_save_time ends
  task automatic save_all();
    nv.delete();
    nv = mem;
    dirty = 1'b0;
    autoSaveNv = autoSaveEn;
    busyN = 1'b0;
    busyCnt = SAVE_T;
  endtask
  // ==========================================================
  // pins are looked at just after each edge
  always @(posedge core_clk) begin
    #1;
    if (busyCnt > 0) begin
      busyCnt--;
      if (busyCnt == 0) begin
        busyN = 1'b1;
        wrArm = 1'b0;
      end
    end else if (saveReqOe && dirty && !lowSupply && pins.chipSelN) begin
      save_all();
    end else if (!pins.chipSelN) begin
      a = pins.addr;
      wd = pins.dqOut;
      if (csLast || (weLast && !pins.writeN)) wrArm = 1'b1;
      wrSeen = wrSeen | (~pins.writeN & wrArm);
    end else if (!csLast) begin
      c = a[13:0];
      if (wrSeen) begin
        step = 0;
        if (!lowSupply) begin
          mem[a] = wd;
          dirty = 1'b1;
        end
      end else if (step == 5) begin
        step = 0;
        case (c)
          NVSC_SAVE: if (!lowSupply) save_all();
          NVSC_LOAD: begin
            mem.delete();
            mem = nv;
            dirty = 1'b0;
            busyCnt = LOAD_T;
          end
          NVSC_ASOFF: autoSaveEn = 1'b0;
          NVSC_ASON: autoSaveEn = 1'b1;
          default: step = (c == NVSC_SEQ0) ? 1 : 0;
        endcase
      end else begin
        step = (c == seq[step]) ? step + 1 : 0;
        if (step == 0 && c == NVSC_SEQ0) step = 1;
      end
      wrSeen = 1'b0;
    end
    csLast = pins.chipSelN;
    weLast = pins.writeN;
    // a released or busy bus flips every bit each cycle instead of holding the last byte
    if (!pins.chipSelN && !pins.outEnN && pins.writeN && busyCnt == 0)
      dqIn = mem.exists(pins.addr) ? mem[pins.addr] : 8'h00;
    else
      dqIn = ~dqIn;
  end
endmodule

// [verif/nvsc_host_test.sv]
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_errors++; $display("Error at %0t: got %0h expected %0h", \
  $time, (g), (e)); end end
module nvsc_host_test
  import nvsc_pkg::*;
;
  // ==========================================================
  // signals and reference state
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  nvsc_req_t req = '0;
  logic lowSupply = 1'b0;
  logic reqReady, rdValid, cmdDone, cmdSkipped, saveReqOut, saveReqOe;
  logic saveIn, skip;
  logic [7:0] rdData, dqIn, rd;
  nvsc_pins_t pins;
  int n_errors = 0;
  int check_count = 0;
  int lowSeen = 0;
  logic [7:0] sramExp [int];
  logic [7:0] nvExp [int];
  logic dirtyExp = 1'b0;
  nvsc_host #(.SAVE_CYC(20), .LOAD_CYC(10)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
    .cmdDone(cmdDone), .cmdSkipped(cmdSkipped), .pins(pins),
    .dqIn(dqIn), .saveReqOut(saveReqOut), .saveReqOe(saveReqOe),
    .saveIn(saveIn), .lowSupply(lowSupply));
  nvsc_nvram_model mdl (
    .core_clk(core_clk), .pins(pins), .saveReqOe(saveReqOe),
    .lowSupply(lowSupply), .dqIn(dqIn), .saveIn(saveIn));
  initial forever #20 core_clk = ~core_clk;
  // busy watch and lock-out of the memory while it is busy
  always @(posedge core_clk) begin
    if (saveIn === 1'b0 && saveReqOe === 1'b0) lowSeen++;
    if (mdl.busyCnt > 1) `CHK(pins.chipSelN, 1'b1)
    if (saveReqOe === 1'b1) `CHK(saveReqOut, 1'b0)
  end
  // ==========================================================
  // closing report
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request, then wait for its end under a bound
  task automatic op(input nvsc_cmd_t c, input logic [14:0] a,
                    input logic [7:0] d);
    int i;
    int hi;
    hi = 0;
    rd = 8'hXX;
    for (i = 0; hi < 3; i++) begin
      if (i > 5000) begin
        `CHK(i, 0)
        close_out();
      end
      @(posedge core_clk);
      #1;
      hi = (reqReady === 1'b1 && saveIn === 1'b1) ? hi + 1 : 0;
    end
    reqValid = 1'b1;
    req = '{cmd: c, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    for (i = 0; !(cmdDone === 1'b1 || cmdSkipped === 1'b1); i++) begin
      if (i > 5000) begin
        `CHK(i, 0)
        close_out();
      end
      @(posedge core_clk);
      #1;
      if (rdValid === 1'b1) rd = rdData;
    end
    skip = cmdSkipped;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    op(NVSC_CMD_WRITE, a, d);
    `CHK(skip, lowSupply)
    if (!lowSupply) begin
      sramExp[a] = d;
      dirtyExp = 1'b1;
    end
  endtask
  task automatic rdc(input logic [14:0] a);
    op(NVSC_CMD_READ, a, 8'h00);
    `CHK(rd, sramExp.exists(a) ? sramExp[a] : 8'h00)
  endtask
  task automatic sw(input nvsc_cmd_t c);
    op(c, 15'h0000, 8'h00);
    `CHK(skip, 1'b0)
    if (c == NVSC_CMD_SWSAVE) nvExp = sramExp;
    if (c == NVSC_CMD_RECALL) sramExp = nvExp;
    if (c == NVSC_CMD_SWSAVE || c == NVSC_CMD_RECALL) dirtyExp = 1'b0;
  endtask
  task automatic hw();
    op(NVSC_CMD_HWSAVE, 15'h0000, 8'h00);
    `CHK(skip, ~dirtyExp)
    if (dirtyExp) nvExp = sramExp;
    dirtyExp = 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int k;
    logic [14:0] ra;
    void'($urandom(32'h70a5609f));
    repeat (20) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    `CHK(mdl.autoSaveEn, 1'b1)
    for (k = 0; k < 6; k++) begin
      ra = 15'($urandom());
      wr(ra, 8'($urandom()));
      rdc(ra);
    end
    $display("test random access done");
    wr(15'h0123, 8'h5A);
    sw(NVSC_CMD_SWSAVE);
    `CHK(lowSeen > 0, 1'b1)
    wr(15'h0123, 8'hA5);
    sw(NVSC_CMD_RECALL);
    rdc(15'h0123);
    sw(NVSC_CMD_RECALL);
    rdc(15'h0123);
    lowSeen = 0;
    sw(NVSC_CMD_SWSAVE);
    `CHK(lowSeen > 0, 1'b1)
    $display("test software save and recall done");
    hw();
    wr(15'h0200, 8'h3C);
    hw();
    wr(15'h0200, 8'h99);
    sw(NVSC_CMD_RECALL);
    rdc(15'h0200);
    $display("test hardware save done");
    sw(NVSC_CMD_ASOFF);
    `CHK(mdl.autoSaveEn, 1'b0)
    `CHK(mdl.autoSaveNv, 1'b1)
    sw(NVSC_CMD_SWSAVE);
    `CHK(mdl.autoSaveNv, 1'b0)
    sw(NVSC_CMD_ASON);
    `CHK(mdl.autoSaveEn, 1'b1)
    $display("test autosave setting done");
    lowSupply = 1'b1;
    wr(15'h0300, 8'h77);
    op(NVSC_CMD_SWSAVE, 15'h0000, 8'h00);
    `CHK(skip, 1'b1)
    lowSupply = 1'b0;
    rdc(15'h0300);
    $display("test low supply done");
    close_out();
  end
endmodule
